// *** logic/dml_pkg.sv ***
/*
  Constants and carrier types for the dot matrix display drive control.
  Assumes a 20 MHz system clock and APB register access from the CPU side.
*/
package dml_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int OSC_HZ        = 32768;    // low_speed_oscillator rate
  localparam int SLOT_OSC_DIV  = 64;       // oscillator periods per slot
  localparam int SLOT_CYCLES   = CLK_HZ / OSC_HZ * SLOT_OSC_DIV
                                 + (CLK_HZ % OSC_HZ) * SLOT_OSC_DIV / OSC_HZ;
  // ---------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_DUTY_SUPPLY_IDX = 16'hFF60;
  localparam logic [15:0] REG_OVR_PAGE_IDX    = 16'hFF61;
  localparam logic [15:0] REG_CONTRAST_IDX    = 16'hFF62;
  localparam logic [7:0]  MEM_PAGE0_HI        = 8'hF0;
  localparam logic [7:0]  MEM_PAGE1_HI        = 8'hF1;
  localparam logic [7:0]  MEM_PAGE2_HI        = 8'hF2;
  localparam logic [7:0]  MEM_ROW_WORDS       = 8'h50;
  localparam logic [7:0]  MEM_COM16_LAST      = 8'h4E;
  localparam logic [7:0]  MEM_PAGE1_BASE      = 8'h50;
  localparam logic [7:0]  MEM_PAGE2_BASE      = 8'hA0;
  localparam int          MEM_WORDS           = 200;
  localparam int          NUM_SEG             = 40;
  localparam int          NUM_COM             = 17;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]  LAST_COM_DUTY8  = 5'h07;
  localparam logic [4:0]  LAST_COM_DUTY16 = 5'h0F;
  localparam logic [4:0]  LAST_COM_DUTY17 = 5'h10;
  localparam logic        ALL_DOTS_OFF_RESET = 1'b1;
  localparam logic [31:0] BUS_ZERO        = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dml_apb_req_t;

  typedef struct packed {
    logic       duty_select_high;
    logic       duty_select_low;
    logic       reference_level_select;
    logic       drive_supply_enable;
    logic       spare_storage_bit;
    logic       all_dots_off;
    logic       all_dots_on;
    logic       display_page_select;
    logic [3:0] contrast_code;
  } dml_ctrl_t;
endpackage

// *** logic/dml_lcd_ctrl.sv ***
/*
  Dot matrix display drive control: control registers, display memory,
  common scan and segment data selection.
  Assumes an APB master on the register side; analog drive levels are
  produced outside from the supply, reference and contrast outputs.
*/
// Decided for this implementation: register access over APB.
// Summary of operation
// - all-on forces every segment on; all-off forces every segment off.
// - with both override bits set, all-on wins.
// - with no override, segments show display memory contents.
// - duty field: high bit set 1/8, 01 gives 1/16, 00 gives 1/17.
// - 1/17 scans commons 0..16, 1/16 scans commons 0..15.
// - 1/8 drives only commons 0..7 with their memory data.
// - frame 32 Hz at 1/8 and 1/16, 30.12 Hz at 1/17 (32.768 kHz).
// - memory bit 1 turns the dot on, 0 turns it off.
// - display memory spans F000H..F24EH, mapped onto common/segment dots.
// - at 1/8 the page bit picks F000H area or F100H area.
// - a page change switches the screen at once.
// - at 1/16 and 1/17 the page bit is plain storage.
// - display memory is read/write; unused bits are general storage.
// - four-bit contrast code gives 16 levels, light to dark.
// - contrast code steers reference level; range set by reference select.
// - with external drive supply the contrast code has no effect.
// - supply enable 1 starts drive generation; 0 grounds drive levels.
// - reset clears the supply enable bit.
module dml_lcd_ctrl import dml_pkg::*; #(
  parameter int SLOT_LEN   = SLOT_CYCLES, // clocks per common slot
  parameter bit EXT_SUPPLY = 1'b0         // drive levels come from outside
) (
  input  wire logic         clock,         // 20 MHz system clock
  input  wire logic         rstn,          // async reset, active low
  input  wire dml_apb_req_t apb_req,       // apb request group
  output logic              pready,        // apb ready
  output logic [31:0]       prdata,        // apb read data
  output logic              pslverr,       // apb error, unmapped address
  output logic [16:0]       com_drive,     // one-hot selected common
  output logic [39:0]       seg_on,        // per segment on waveform
  output logic              drive_supply_on, // drive level generator on
  output logic              reference_level_select, // reference range
  output logic [3:0]        contrast_out   // contrast code to regulator
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dml_ctrl_t   ctrl;
    logic [15:0] slot_cnt;
    logic        half;
    logic [4:0]  com_idx;
    logic [16:0] com_drive;
    logic [39:0] seg_on;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  contrast_out;
  } dml_state_t;

  dml_state_t cur;
  dml_state_t next_cur;
  logic [3:0] mem [0:MEM_WORDS-1];

  logic [15:0] word_idx;
  logic        addr_high_zero;
  logic        mem_hit;
  logic [7:0]  mem_idx;
  logic        reg_hit;
  logic [3:0]  rd_nib;
  logic        wr_done;
  logic        duty8;
  logic [4:0]  last_com;
  logic        slot_tick;
  logic [39:0] seg_data;
  logic [7:0]  row_base;

  assign word_idx       = apb_req.paddr[17:2];
  assign addr_high_zero = (apb_req.paddr[31:18] == 14'h0000)
                          && (apb_req.paddr[1:0] == 2'h0);
  assign duty8 = cur.ctrl.duty_select_high;
  assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite
                   && cur.pready;
  assign slot_tick = (cur.slot_cnt == 16'(SLOT_LEN - 1));

  // ---------------------------------------------------------------
  // address decode for display memory
  // ---------------------------------------------------------------
  always_comb begin
    mem_hit = 1'b0;
    mem_idx = 8'h00;
    if (addr_high_zero) begin
      if (word_idx[15:8] == MEM_PAGE0_HI && word_idx[7:0] < MEM_ROW_WORDS)
      begin
        mem_hit = 1'b1;
        mem_idx = word_idx[7:0];
      end else if (word_idx[15:8] == MEM_PAGE1_HI
                   && word_idx[7:0] < MEM_ROW_WORDS) begin
        mem_hit = 1'b1;
        mem_idx = MEM_PAGE1_BASE + word_idx[7:0];
      end else if (word_idx[15:8] == MEM_PAGE2_HI
                   && word_idx[7:0] <= MEM_COM16_LAST && !word_idx[0]) begin
        mem_hit = 1'b1;
        mem_idx = MEM_PAGE2_BASE + {1'b0, word_idx[7:1]};
      end
    end
  end

  always_comb begin
    reg_hit = addr_high_zero && (word_idx == REG_DUTY_SUPPLY_IDX
              || word_idx == REG_OVR_PAGE_IDX || word_idx == REG_CONTRAST_IDX);
    case (word_idx)
      REG_DUTY_SUPPLY_IDX: rd_nib = {cur.ctrl.duty_select_high,
                                     cur.ctrl.duty_select_low,
                                     cur.ctrl.reference_level_select,
                                     cur.ctrl.drive_supply_enable};
      REG_OVR_PAGE_IDX:    rd_nib = {cur.ctrl.spare_storage_bit,
                                     cur.ctrl.all_dots_off,
                                     cur.ctrl.all_dots_on,
                                     cur.ctrl.display_page_select};
      REG_CONTRAST_IDX:    rd_nib = cur.ctrl.contrast_code;
      default:             rd_nib = mem[mem_idx];
    endcase
  end

  // ---------------------------------------------------------------
  // segment data for the common now selected
  // ---------------------------------------------------------------
  // page 1 feeds commons 0..7 only at 1/8; otherwise the bit is inert
  assign row_base = (cur.com_idx[3] || (duty8 && cur.ctrl.display_page_select))
                    ? MEM_PAGE1_BASE : 8'h00;

  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      localparam logic [7:0] SEG_PAIR = 8'(2 * g);
      localparam logic [7:0] SEG_C16  = 8'(g);
      assign seg_data[g] = (cur.com_idx == LAST_COM_DUTY17)
        ? mem[MEM_PAGE2_BASE + SEG_C16][0]
        : mem[row_base + SEG_PAIR + {7'h00, cur.com_idx[2]}]
             [cur.com_idx[1:0]];
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // last active common per duty
    if (duty8) begin
      last_com = LAST_COM_DUTY8;
    end else if (cur.ctrl.duty_select_low) begin
      last_com = LAST_COM_DUTY16;
    end else begin
      last_com = LAST_COM_DUTY17;
    end

    // apb: ready one cycle after setup, no wait states beyond that
    next_cur.pready  = apb_req.psel && !apb_req.penable;
    next_cur.pslverr = apb_req.psel && !apb_req.penable
                       && !(reg_hit || mem_hit);
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      next_cur.prdata = (reg_hit || mem_hit) ? {28'h0000000, rd_nib}
                                             : BUS_ZERO;
    end

    if (wr_done && reg_hit) begin
      case (word_idx)
        REG_DUTY_SUPPLY_IDX: begin
          next_cur.ctrl.duty_select_high       = apb_req.pwdata[3];
          next_cur.ctrl.duty_select_low        = apb_req.pwdata[2];
          next_cur.ctrl.reference_level_select = apb_req.pwdata[1];
          next_cur.ctrl.drive_supply_enable    = apb_req.pwdata[0];
        end
        REG_OVR_PAGE_IDX: begin
          next_cur.ctrl.spare_storage_bit   = apb_req.pwdata[3];
          next_cur.ctrl.all_dots_off        = apb_req.pwdata[2];
          next_cur.ctrl.all_dots_on         = apb_req.pwdata[1];
          next_cur.ctrl.display_page_select = apb_req.pwdata[0];
        end
        default: next_cur.ctrl.contrast_code = apb_req.pwdata[3:0];
      endcase
    end

    // slot timing: 1/8 holds each common for two base slots so the
    // frame rate matches 1/16 (32 Hz) while 1/17 gives 30.12 Hz
    next_cur.slot_cnt = slot_tick ? 16'h0000 : cur.slot_cnt + 16'h0001;
    if (cur.com_idx > last_com) begin
      next_cur.com_idx = 5'h00;                // duty narrowed mid frame
      next_cur.half    = 1'b0;
    end else if (slot_tick) begin
      next_cur.half = duty8 ? !cur.half : 1'b0;
      if (!duty8 || cur.half) begin
        next_cur.com_idx = (cur.com_idx == last_com) ? 5'h00
                           : cur.com_idx + 5'h01;
      end
    end
    next_cur.com_drive = 17'h00001 << cur.com_idx;

    if (cur.ctrl.all_dots_on) begin
      next_cur.seg_on = {NUM_SEG{1'b1}};
    end else if (cur.ctrl.all_dots_off) begin
      next_cur.seg_on = {NUM_SEG{1'b0}};
    end else begin
      next_cur.seg_on = seg_data;
    end
    next_cur.contrast_out = EXT_SUPPLY ? 4'h0
                            : cur.ctrl.contrast_code;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
      cur.ctrl.all_dots_off <= ALL_DOTS_OFF_RESET;
      cur.com_drive <= 17'h00001;
    end else begin
      cur <= next_cur;
    end
  end

  // memory contents are left undefined by reset; software fills them
  always_ff @(posedge clock) begin
    if (wr_done && mem_hit) begin
      mem[mem_idx] <= apb_req.pwdata[3:0];
    end
  end

  assign pready                 = cur.pready;
  assign prdata                 = cur.prdata;
  assign pslverr                = cur.pslverr;
  assign com_drive              = cur.com_drive;
  assign seg_on                 = cur.seg_on;
  assign drive_supply_on        = cur.ctrl.drive_supply_enable;
  assign reference_level_select = cur.ctrl.reference_level_select;
  assign contrast_out           = cur.contrast_out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_ALL_ON: assert property (
    cur.ctrl.all_dots_on |=> seg_on == {NUM_SEG{1'b1}})
    else $error("all-on did not force segments on");
  AST_ALL_OFF: assert property (
    cur.ctrl.all_dots_off && !cur.ctrl.all_dots_on |=> seg_on == '0)
    else $error("all-off did not force segments off");
  AST_NORMAL: assert property (
    !cur.ctrl.all_dots_on && !cur.ctrl.all_dots_off
      |=> seg_on == $past(seg_data))
    else $error("normal display not taken from memory");
  AST_DUTY8_RANGE: assert property (
    duty8 && $stable(duty8) |-> cur.com_idx <= LAST_COM_DUTY8)
    else $error("common beyond 7 at 1/8 duty");
  AST_DUTY16_RANGE: assert property (
    !duty8 && cur.ctrl.duty_select_low && $stable(cur.ctrl)
      |-> cur.com_idx <= LAST_COM_DUTY16)
    else $error("common beyond 15 at 1/16 duty");
  AST_SCAN_STEP: assert property (
    slot_tick && !duty8 && cur.com_idx < last_com
      |=> cur.com_idx == $past(cur.com_idx) + 5'h01)
    else $error("common did not advance by one");
  AST_COM_ONEHOT: assert property (
    com_drive == 17'h00001 << $past(cur.com_idx))
    else $error("common output not one-hot at scan index");
  AST_SUPPLY_OFF: assert property (
    wr_done && word_idx == REG_DUTY_SUPPLY_IDX && reg_hit
      && !apb_req.pwdata[0] |=> !drive_supply_on)
    else $error("supply enable not cleared by write");
  AST_CONTRAST: assert property (
    wr_done && word_idx == REG_CONTRAST_IDX && reg_hit
      |=> ##1 contrast_out
        == (EXT_SUPPLY ? 4'h0 : $past(apb_req.pwdata[3:0], 2)))
    else $error("contrast output wrong after write");
  AST_APB_READY: assert property (
    apb_req.psel && !apb_req.penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");

  // ---------------------------------------------------------------
  // checks on register writes, scan timing and the bus decode
  // ---------------------------------------------------------------
  AST_RESET_SUPPLY: assert property (
    $rose(rstn) |-> !drive_supply_on && com_drive == 17'h00001)
    else $error("supply or scan not at rest after reset");

  AST_SUPPLY_ON: assert property (
    wr_done && word_idx == REG_DUTY_SUPPLY_IDX && reg_hit
      && apb_req.pwdata[0] |=> drive_supply_on)
    else $error("supply enable not set by write");
  AST_REF_SEL: assert property (
    wr_done && word_idx == REG_DUTY_SUPPLY_IDX && reg_hit
      |=> reference_level_select == $past(apb_req.pwdata[1]))
    else $error("reference select not taken from write");
  AST_DUTY_WRITE: assert property (
    wr_done && word_idx == REG_DUTY_SUPPLY_IDX && reg_hit
      |=> duty8 == $past(apb_req.pwdata[3]))
    else $error("duty field not taken from write");
  AST_OVR_WRITE: assert property (
    wr_done && word_idx == REG_OVR_PAGE_IDX && reg_hit
      |=> cur.ctrl.all_dots_on == $past(apb_req.pwdata[1])
          && cur.ctrl.all_dots_off == $past(apb_req.pwdata[2]))
    else $error("override bits not taken from write");
  AST_PAGE_WRITE: assert property (
    wr_done && word_idx == REG_OVR_PAGE_IDX && reg_hit
      |=> cur.ctrl.display_page_select == $past(apb_req.pwdata[0]))
    else $error("page bit not kept as written");
  AST_CTRL_HOLD: assert property (
    !(wr_done && reg_hit) |=> $stable(cur.ctrl))
    else $error("control bits changed without a write");

  // the area switch is combinational, so a page write shows at once
  AST_PAGE_SEL: assert property (
    duty8 && cur.com_idx <= LAST_COM_DUTY8
      |-> row_base == (cur.ctrl.display_page_select ? MEM_PAGE1_BASE
                                                    : 8'h00))
    else $error("page bit did not pick the displayed area");
  AST_PAGE_INERT: assert property (
    !duty8 && !cur.com_idx[3] |-> row_base == 8'h00)
    else $error("page bit moved the display at 1/16 or 1/17");

  AST_SLOT_WRAP: assert property (
    slot_tick |=> cur.slot_cnt == 16'h0000)
    else $error("slot counter did not wrap");
  AST_SLOT_COUNT: assert property (
    !slot_tick |=> cur.slot_cnt == $past(cur.slot_cnt) + 16'h0001)
    else $error("slot counter skipped");
  AST_HALF_HOLD: assert property (
    slot_tick && duty8 && !cur.half && cur.com_idx <= LAST_COM_DUTY8
      |=> $stable(cur.com_idx))
    else $error("1/8 common left after one slot");
  AST_DUTY8_STEP: assert property (
    slot_tick && duty8 && cur.half && cur.com_idx < LAST_COM_DUTY8
      |=> cur.com_idx == $past(cur.com_idx) + 5'h01)
    else $error("1/8 common did not advance after two slots");
  AST_SCAN_WRAP: assert property (
    slot_tick && cur.com_idx == last_com && (!duty8 || cur.half)
      |=> cur.com_idx == 5'h00)
    else $error("scan did not wrap to common 0");
  AST_SCAN_HOLD: assert property (
    !slot_tick && cur.com_idx <= last_com |=> $stable(cur.com_idx))
    else $error("common changed inside a slot");

  AST_COM_MAX: assert property (
    cur.com_idx <= LAST_COM_DUTY17)
    else $error("common index beyond 16");
  // common 16 takes bit 0 of the even words in the third area
  AST_COM16_DATA: assert property (
    cur.com_idx == LAST_COM_DUTY17 && !cur.ctrl.all_dots_on
      && !cur.ctrl.all_dots_off
      |=> seg_on[0] == $past(mem[MEM_PAGE2_BASE][0]))
    else $error("common 16 segment 0 not from its memory word");
  AST_UNMAPPED: assert property (
    apb_req.psel && !apb_req.penable && !apb_req.pwrite
      && !(reg_hit || mem_hit) |=> pslverr && prdata == BUS_ZERO)
    else $error("unmapped read not refused");
  AST_WR_MEM: assert property (
    wr_done && mem_hit
      |=> mem[$past(mem_idx)] == $past(apb_req.pwdata[3:0]))
    else $error("display memory write lost");
  AST_RD_MEM: assert property (
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && mem_hit
      |=> prdata[3:0] == $past(mem[mem_idx]))
    else $error("display memory read wrong");

  COV_BOTH_OVR: cover property (cur.ctrl.all_dots_on && cur.ctrl.all_dots_off);
  COV_PAGE1: cover property (duty8 && cur.ctrl.display_page_select
                             && slot_tick);
  COV_WRAP17: cover property (slot_tick && cur.com_idx == LAST_COM_DUTY17);
  COV_UNMAPPED: cover property (pslverr);
endmodule

// *** verification/dml_panel_model.sv ***
/*
  Dot matrix panel model: watches common and segment drive, keeps the
  dots seen per common, slot length and scan order.
  Assumes one-hot commons and settled segment data in a slot's last cycle.
*/
module dml_panel_model
  import dml_pkg::*;
(
  input  wire logic [16:0] com_drive,    // one-hot common
  input  wire logic [39:0] seg_on,       // segment on waveforms
  input  wire logic        clock,        // system clock
  input  wire logic        rstn,         // async reset, active low
  output logic [39:0]      image [0:16], // dots seen per common
  output int               top_com,      // highest common of last frame
  output int               slot_len,     // clocks of last slot
  output int               order_err     // steps out of sequence
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] cur;
  logic [39:0] hold;
  int          run;
  int          top;

  function automatic int idx(logic [16:0] v);
    for (int i = 0; i < 17; i++) if (v[i] === 1'h1) return i;
    return -1;
  endfunction

  // segment data changes on the same edge as the common, so keep the value seen before the change
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur = 17'h00001;
      run = 0;
      top = 0;
      order_err = 0;
      slot_len = 0;
      top_com = 0;
    end else begin
      run++;
      if (com_drive !== cur) begin
        image[idx(cur)] = hold;
        slot_len = run;
        run = 0;
        if (idx(com_drive) == 0) top_com = top;
        else if (idx(com_drive) != idx(cur) + 1) order_err++;
        top = idx(com_drive);
        cur = com_drive;
      end
      hold = seg_on;
    end
  end
endmodule

// *** verification/dml_lcd_ctrl_tb_top.sv ***
/*
  Self-checking bench for the display drive control: APB master, model of
  registers and display memory, panel model on the drive outputs.
  Assumes zero-wait APB slave and a shortened slot length.
*/
module dml_lcd_ctrl_tb_top
  import dml_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SL = 8;
  logic         clock = 1'h0;
  logic         rstn  = 1'h0;
  dml_apb_req_t req   = '0;
  logic         pready, pslverr, supply, refsel;
  logic [31:0]  prdata, rd;
  logic [16:0]  com;
  logic [39:0]  seg;
  logic [39:0]  image [0:16];
  logic [3:0]   contrast, r60, r61, ct;
  logic [3:0]   mem_m [0:591];
  logic [4:0]   cfg [0:7] = '{5'h00, 5'h09, 5'h10, 5'h11, 5'h19, 5'h02,
                              5'h05, 5'h0E};
  logic         er;
  int           top_com, slot_len, order_err, a, last;
  int           miscompares = 0, n_tests = 0, seed = 34176, cyc = 0;

  dml_lcd_ctrl #(.SLOT_LEN(SL), .EXT_SUPPLY(1'h0)) DUT (
    .clock(clock), .rstn(rstn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .com_drive(com), .seg_on(seg),
    .drive_supply_on(supply), .reference_level_select(refsel),
    .contrast_out(contrast));
  dml_panel_model PANEL (
    .com_drive(com), .seg_on(seg), .clock(clock), .rstn(rstn),
    .image(image), .top_com(top_com), .slot_len(slot_len),
    .order_err(order_err));

  always #25 clock = ~clock;
  // ------------------------------------------------------------
  // timeout: whole run needs about 4900 cycles
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      results();
    end
  end

  task results;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one APB transfer; waits for pready at a rising edge, then releases
  task apb(input logic w, input logic [15:0] idx, input logic [3:0] d);
    @(posedge clock);
    req.psel <= 1'h1;
    req.penable <= 1'h0;
    req.pwrite <= w;
    req.paddr <= {14'h0000, idx, 2'h0};
    req.pwdata <= {28'h0000000, d};
    @(posedge clock);
    req.penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask

  function automatic logic [39:0] exp_seg(int c);
    logic [39:0] v;
    int          m;
    for (int s = 0; s < 40; s++) begin
      m = (c == 16) ? 'h200 + 2 * s :
          ((c >= 8 || (r60[3] && r61[0])) ? 'h100 : 0) + 2 * s + (c >> 2) % 2;
      v[s] = mem_m[m][c % 4];
    end
    if (r61[1]) v = '1;
    else if (r61[2]) v = '0;
    return v;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'h1;
    apb(1'h0, REG_DUTY_SUPPLY_IDX, 4'h0);
    check(rd, 40'h0);
    check(supply, 40'h0);
    apb(1'h0, REG_OVR_PAGE_IDX, 4'h0);
    check(rd, 40'h4);
    apb(1'h0, 16'hFF63, 4'h0);
    check({er, rd}, 40'h100000000);
    // software sets every display word before use
    for (int i = 0; i < 200; i++) begin
      a = i < 80 ? i : i < 160 ? 'h100 + i - 80 : 'h200 + 2 * (i - 160);
      mem_m[a] = 4'($random(seed));
      apb(1'h1, 16'(16'hF000 + a), mem_m[a]);
      apb(1'h0, 16'(16'hF000 + a), 4'h0);
      check(rd, mem_m[a]);
    end
    for (int k = 0; k < 8; k++) begin
      r61 = {1'($random(seed)), cfg[k][2:0]};
      r60 = {cfg[k][4:3], 2'($random(seed))};
      ct = 4'($random(seed));
      apb(1'h1, REG_OVR_PAGE_IDX, r61);
      apb(1'h1, REG_DUTY_SUPPLY_IDX, r60);
      apb(1'h1, REG_CONTRAST_IDX, ct);
      repeat (450) @(posedge clock);
      check(supply, r60[0]);
      check(refsel, r60[1]);
      check(contrast, ct);
      apb(1'h0, REG_OVR_PAGE_IDX, 4'h0);
      check(rd, r61);
      last = r60[3] ? 7 : r60[2] ? 15 : 16;
      check(top_com, last);
      check(slot_len, r60[3] ? 2 * SL : SL);
      for (int c = 0; c <= last; c++) check(image[c], exp_seg(c));
    end
    check(order_err, 40'h0);
    results();
  end
endmodule
